// ### llc_defines.svh
// register offsets, field positions and reset values of the loopback control block
`ifndef LLC_DEFINES_SVH
`define LLC_DEFINES_SVH

`define LLC_ADDR_OAM_CFG    8'h40
`define LLC_ADDR_PHY_INIT   8'h43
`define LLC_ADDR_LB_CMD     8'h44
`define LLC_ADDR_LB_CRC     8'h46

`define LLC_BIT_PHY_RST     0
`define LLC_BIT_TX_TRI      1
`define LLC_BIT_LL_EN       2
`define LLC_BIT_SOFT_RST    4

`define LLC_LB_CMD_RESET    8'h07
`define LLC_LB_CMD_CLEAR    8'h00
`define LLC_LB_CMD_MIN      8'h01
`define LLC_LB_CMD_MAX      8'h64

`define LLC_CRC_CNT_RESET   8'h00
`define LLC_CRC_CNT_FULL    8'hff
`define LLC_RD_ZERO         8'h00

`endif

// ### llc_pkg.sv
// types shared by the loopback control block
package llc_pkg;

  // loopback burst sequencer states
  typedef enum logic [1:0] {
    LLC_SEQ_IDLE,
    LLC_SEQ_SEND,
    LLC_SEQ_WAIT
  } llc_seq_state_e;

  // packet count of a burst
  typedef logic [6:0] llc_count_t;

endpackage

// ### llc_lb_seq.sv
// loopback burst sequencer: issues a counted run of packet requests
`timescale 1ns/1ps
`include "llc_defines.svh"

module llc_lb_seq #(
  parameter int CNT_W = 7                  // width of the packet count
) (
  input  wire logic             ref_clk,   // device clock
  input  wire logic             reset_n,   // synchronous reset, active low
  input  wire logic             start,     // one-cycle burst launch
  input  wire logic [CNT_W-1:0] count,     // packets in the burst
  input  wire logic             abort,     // drop the running burst
  input  wire logic             pkt_done,  // one-cycle: packet has gone out
  output logic                  pkt_req    // one-cycle: send one packet
);

  // count must hold the largest legal burst, refused at elaboration
  if (CNT_W < 7) begin : g_cnt_w_check
    $error("llc_lb_seq: CNT_W too small");
  end

  llc_pkg::llc_seq_state_e state;          // sequencer state
  logic [CNT_W-1:0]        remaining;      // packets still to send

  // state walk: send, wait for done, repeat until none remain
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= llc_pkg::LLC_SEQ_IDLE;
    end else if (abort) begin
      state <= llc_pkg::LLC_SEQ_IDLE;
    end else if (start) begin
      state <= llc_pkg::LLC_SEQ_SEND;      // a fresh write starts anew
    end else begin
      unique case (state)
        llc_pkg::LLC_SEQ_IDLE: begin
          state <= llc_pkg::LLC_SEQ_IDLE;
        end
        llc_pkg::LLC_SEQ_SEND: begin
          state <= llc_pkg::LLC_SEQ_WAIT;
        end
        llc_pkg::LLC_SEQ_WAIT: begin
          if (pkt_done && remaining == CNT_W'(1)) begin
            state <= llc_pkg::LLC_SEQ_IDLE;  // burst complete
          end else if (pkt_done) begin
            state <= llc_pkg::LLC_SEQ_SEND;
          end
        end
      endcase
    end
  end

  // remaining packet counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      remaining <= '0;
    end else if (start) begin
      remaining <= count;                  // exactly count packets when count is nonzero
    end else if (state == llc_pkg::LLC_SEQ_WAIT && pkt_done) begin
      remaining <= remaining - CNT_W'(1);
    end
  end

  // request pulse, one per send state
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pkt_req <= 1'b0;
    end else begin
      pkt_req <= (state == llc_pkg::LLC_SEQ_SEND) && !abort && !start;
    end
  end

  a_req_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pkt_req |=> !pkt_req) else $error("packet request longer than one cycle");

  a_burst_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state == llc_pkg::LLC_SEQ_WAIT && pkt_done && remaining == CNT_W'(1) && !start && !abort)
    |=> !pkt_req[*2]) else $error("request after last packet of burst");

endmodule

// ### llc_regs.sv
// media converter maintenance control registers and loopback launch logic
`timescale 1ns/1ps
`include "llc_defines.svh"

// Function
// - terminal mode: link loss kills copper tx, leds
// - center mode ignores link-loss propagation bit
// - fiber transmit tristate bit disables fiber tx
// - phy reset bit resets both phys
// - phy reset bit clears itself
// - phy reset leaves maintenance registers alone
// - center mode: phy reset on until 0x40
// - other modes: phy reset starts at zero
// - zero command clears valid tx/rx counters
// - center zero command also clears loopback counters
// - center command 1..100 sends that many packets
// - loopback command resets to seven
// - soft reset resets sublayer, macs, fabric; self-clears
// - center side counts returned crc errors
module llc_regs (
  input  wire logic       ref_clk,                // device clock, 20 MHz
  input  wire logic       reset_n,                // synchronous reset, active low
  input  wire logic       center_mode,            // 1: center side, 0: terminal
  input  wire logic       link_loss_strap,        // strap level for propagation bit
  input  wire logic       reg_wr,                 // register write strobe
  input  wire logic       reg_rd,                 // register read strobe
  input  wire logic [7:0] reg_addr,               // register offset
  input  wire logic [7:0] reg_wdata,              // write data
  input  wire logic       fiber_link_down,        // fiber link lost
  input  wire logic       center_copper_link_down,// far copper link lost
  input  wire logic       lb_crc_err,             // returned packet had crc error
  input  wire logic       lb_pkt_done,            // loopback packet sent
  output logic      [7:0] reg_rdata,              // read data
  output logic            copper_tx_disable,      // copper transmit off
  output logic            copper_led_off,         // copper leds off
  output logic            fiber_tx_tristate,      // fiber transmit tristated
  output logic            phy_reset,              // both phys held in reset
  output logic            mac_fabric_reset,       // macs and fabric reset pulse
  output logic            clr_valid_cnt,          // clear valid tx/rx counters
  output logic            clr_lb_cnt,             // clear loopback result counters
  output logic            lb_pkt_req              // send one loopback packet
);

  logic       link_loss_propagate_en;  // propagation enable bit
  logic       init_hold;               // phy reset held until 0x40 written
  logic [7:0] loopback_command;        // loopback command field
  logic [7:0] crc_err_cnt;             // loopback crc error counter
  logic       lb_start;                // one-cycle burst launch
  logic [6:0] lb_count;                // burst length for the sequencer

  // decoded write strobes
  logic wr_oam;                        // write to 0x40
  logic wr_init;                       // write to phy init control
  logic wr_cmd;                        // write to loopback command
  logic soft_rst_wr;                   // software reset requested
  logic cmd_clear;                     // all-zero command written
  logic cmd_send;                      // legal packet count written

  // true when a byte is a legal packet count
  function automatic logic is_send_count(input logic [7:0] v);
    return (v >= `LLC_LB_CMD_MIN) && (v <= `LLC_LB_CMD_MAX);
  endfunction

  // address and field decode
  always_comb begin
    wr_oam      = reg_wr && (reg_addr == `LLC_ADDR_OAM_CFG);
    wr_init     = reg_wr && (reg_addr == `LLC_ADDR_PHY_INIT);
    wr_cmd      = reg_wr && (reg_addr == `LLC_ADDR_LB_CMD);
    soft_rst_wr = wr_init && reg_wdata[`LLC_BIT_SOFT_RST];
    cmd_clear   = wr_cmd && (reg_wdata == `LLC_LB_CMD_CLEAR);
    cmd_send    = wr_cmd && center_mode && is_send_count(reg_wdata);
  end

  // propagation enable: strap caught during reset, then writable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      link_loss_propagate_en <= link_loss_strap;
    end else if (wr_init) begin
      link_loss_propagate_en <= reg_wdata[`LLC_BIT_LL_EN];
    end
  end

  // fiber transmit tristate bit drives the pin directly
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fiber_tx_tristate <= 1'b0;
    end else if (wr_init) begin
      fiber_tx_tristate <= reg_wdata[`LLC_BIT_TX_TRI];
    end
  end

  // center mode holds the phys in reset until 0x40 is programmed
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      init_hold <= center_mode;
    end else if (wr_oam) begin
      init_hold <= 1'b0;
    end
  end

  // phy reset bit: set by a write of 1, self-clears unless held
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phy_reset <= center_mode;
    end else if (wr_init && reg_wdata[`LLC_BIT_PHY_RST]) begin
      phy_reset <= 1'b1;
    end else if (init_hold && !wr_oam) begin
      phy_reset <= phy_reset;
    end else begin
      phy_reset <= 1'b0;
    end
  end

  // software reset: one-cycle pulse, bit reads back as zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mac_fabric_reset <= 1'b0;
    end else begin
      mac_fabric_reset <= soft_rst_wr;
    end
  end

  // loopback command field; phy reset never touches it
  always_ff @(posedge ref_clk) begin
    if (!reset_n || soft_rst_wr) begin
      loopback_command <= `LLC_LB_CMD_RESET;
    end else if (wr_cmd) begin
      loopback_command <= reg_wdata;
    end
  end

  // burst launch, once per qualifying write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lb_start <= 1'b0;
      lb_count <= '0;
    end else begin
      lb_start <= cmd_send && !soft_rst_wr;
      if (cmd_send) begin
        lb_count <= reg_wdata[6:0];
      end
    end
  end

  // counter clear pulses for the external counters
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clr_valid_cnt <= 1'b0;
      clr_lb_cnt    <= 1'b0;
    end else begin
      clr_valid_cnt <= cmd_clear;
      clr_lb_cnt    <= cmd_clear && center_mode;
    end
  end

  // crc error counter: clear wins for the clear command and for soft reset, saturates
  always_ff @(posedge ref_clk) begin
    if (!reset_n || soft_rst_wr) begin
      crc_err_cnt <= `LLC_CRC_CNT_RESET;
    end else if (cmd_clear && center_mode) begin
      crc_err_cnt <= `LLC_CRC_CNT_RESET;
    end else if (center_mode && lb_crc_err && crc_err_cnt != `LLC_CRC_CNT_FULL) begin
      crc_err_cnt <= crc_err_cnt + 8'h01;
    end
  end

  // link-loss propagation toward copper, terminal mode only
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      copper_tx_disable <= 1'b0;
      copper_led_off    <= 1'b0;
    end else begin
      copper_tx_disable <= !center_mode && link_loss_propagate_en
                           && (fiber_link_down || center_copper_link_down);
      copper_led_off    <= !center_mode && link_loss_propagate_en
                           && (fiber_link_down || center_copper_link_down);
    end
  end

  // read data, registered on the read strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= `LLC_RD_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `LLC_ADDR_PHY_INIT: begin
          reg_rdata <= {5'h00, link_loss_propagate_en, fiber_tx_tristate, phy_reset};
        end
        `LLC_ADDR_LB_CMD: begin
          reg_rdata <= loopback_command;
        end
        `LLC_ADDR_LB_CRC: begin
          reg_rdata <= crc_err_cnt;
        end
        default: begin
          reg_rdata <= `LLC_RD_ZERO;
        end
      endcase
    end
  end

  // packet sequencer; values 0x65..0xff never launch
  llc_lb_seq #(
    .CNT_W    (7)
  ) u_seq (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .start    (lb_start),
    .count    (lb_count),
    .abort    (mac_fabric_reset),
    .pkt_done (lb_pkt_done),
    .pkt_req  (lb_pkt_req)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_cmd_write_count;
    wr_cmd && center_mode && is_send_count(reg_wdata) && !soft_rst_wr;
  endsequence

  sequence s_launch;
    lb_start ##1 (lb_count != 7'h00);
  endsequence

  a_link_loss_prop: assert property (
    (!center_mode && link_loss_propagate_en && fiber_link_down)
    |=> (copper_tx_disable && copper_led_off))
    else $error("link loss did not reach copper");

  a_center_ignore: assert property (
    center_mode |=> (!copper_tx_disable && !copper_led_off))
    else $error("center mode used propagation bit");

  a_tristate_set: assert property (
    wr_init |=> (fiber_tx_tristate == $past(reg_wdata[`LLC_BIT_TX_TRI])))
    else $error("fiber tristate not applied");

  a_phy_rst_clear: assert property (
    (phy_reset && !init_hold && !wr_init) |=> !phy_reset) else $error("phy reset stuck");

  a_phy_rst_hold: assert property (
    init_hold |-> phy_reset) else $error("phy reset dropped before 0x40 write");

  a_phy_rst_init: assert property (@(posedge ref_clk) disable iff (1'b0)
    (!reset_n && !center_mode) |=> !phy_reset) else $error("phy reset set out of reset");

  a_clear_pulses: assert property (
    (cmd_clear && center_mode) |=> (clr_valid_cnt && clr_lb_cnt && crc_err_cnt == 8'h00))
    else $error("zero command did not clear counters");

  a_burst_launch: assert property (
    s_cmd_write_count |=> s_launch ##[1:3] lb_pkt_req) else $error("burst not launched");

  a_soft_reset: assert property (
    soft_rst_wr |=> (mac_fabric_reset && loopback_command == `LLC_LB_CMD_RESET))
    else $error("software reset not applied");

  a_crc_count: assert property (
    (center_mode && lb_crc_err && !wr_cmd && !soft_rst_wr
     && crc_err_cnt != `LLC_CRC_CNT_FULL)
    |=> crc_err_cnt == $past(crc_err_cnt) + 8'h01) else $error("crc error not counted");

endmodule

// ### llc_far_model.sv
// far side model: sends each requested loopback packet and reports it done
`timescale 1ns/1ps
module llc_far_model (
  input  wire logic ref_clk,     // device clock
  input  wire logic reset_n,     // synchronous reset, active low
  input  wire logic lb_pkt_req,  // send one packet
  input  wire logic bad_crc,     // returned packets carry crc errors
  output logic      lb_pkt_done, // one-cycle: packet has gone out
  output logic      lb_crc_err   // one-cycle: returned packet crc error
);
  int cd; // cycles left until done

  // random 1..4 cycle send time, pulses only while a packet is outstanding
  always @(posedge ref_clk) begin
    lb_pkt_done <= 1'b0;
    lb_crc_err  <= 1'b0;
    if (!reset_n) begin
      cd <= 0;
    end else if (lb_pkt_req) begin
      cd <= 1 + $urandom % 4;
    end else if (cd == 1) begin
      cd          <= 0;
      lb_pkt_done <= 1'b1;
      lb_crc_err  <= bad_crc;
    end else if (cd > 0) begin
      cd <= cd - 1;
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the loopback control registers
`timescale 1ns/1ps
`include "llc_defines.svh"
module testbench;
  logic       ref_clk, reset_n, center_mode, link_loss_strap;         // clock, reset, straps
  logic       reg_wr, reg_rd, fiber_link_down, center_copper_link_down; // bus, links
  logic [7:0] reg_addr, reg_wdata, reg_rdata;                         // register bus
  logic       lb_crc_err, lb_pkt_done, copper_tx_disable, copper_led_off; // outputs
  logic       fiber_tx_tristate, phy_reset, mac_fabric_reset, bad_crc; // outputs, model knob
  logic       clr_valid_cnt, clr_lb_cnt, lb_pkt_req;                  // pulses
  int         err_count, n_tests, cyc, n_req, n_cv, n_cl, n_mac, n_phy; // counters
  int         m_crc, n;                                               // model crc count, size

  llc_regs i_dut (.ref_clk, .reset_n, .center_mode, .link_loss_strap, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .fiber_link_down, .center_copper_link_down, .lb_crc_err,
    .lb_pkt_done, .reg_rdata, .copper_tx_disable, .copper_led_off, .fiber_tx_tristate,
    .phy_reset, .mac_fabric_reset, .clr_valid_cnt, .clr_lb_cnt, .lb_pkt_req);

  llc_far_model i_far (.ref_clk, .reset_n, .lb_pkt_req, .bad_crc, .lb_pkt_done, .lb_crc_err);

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // pulse counters and hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (lb_pkt_req === 1'b1) n_req++;
    if (clr_valid_cnt === 1'b1) n_cv++;
    if (clr_lb_cnt === 1'b1) n_cl++;
    if (mac_fabric_reset === 1'b1) n_mac++;
    if (phy_reset === 1'b1) n_phy++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // verdict and end of run
  task automatic summarize;
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // one register read, data checked a cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // reset with chosen mode and strap
  task automatic rst(input logic cm, input logic st);
    @(posedge ref_clk);
    reset_n         <= 1'b0;
    center_mode     <= cm;
    link_loss_strap <= st;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  // set link levels and check copper outputs
  task automatic link(input logic f, input logic c, input logic [1:0] e);
    @(posedge ref_clk);
    fiber_link_down         <= f;
    center_copper_link_down <= c;
    repeat (3) @(posedge ref_clk);
    #1 chk({copper_tx_disable, copper_led_off}, e);
  endtask

  // command write and count of packets requested
  task automatic burst(input logic [7:0] v, input int exp);
    n_req = 0;
    wr(`LLC_ADDR_LB_CMD, v);
    repeat (exp * 10 + 20) @(posedge ref_clk);
    chk(8'(n_req), 8'(exp));
  endtask

  // zero command and its clear pulses
  task automatic zcmd(input int exp_cl);
    n_cv = 0;
    n_cl = 0;
    wr(`LLC_ADDR_LB_CMD, `LLC_LB_CMD_CLEAR);
    repeat (4) @(posedge ref_clk);
    chk(8'(n_cv), 8'h01);
    chk(8'(n_cl), 8'(exp_cl));
  endtask

  // main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, fiber_link_down, center_copper_link_down, bad_crc} = '0;
    center_mode     = 1'b0;
    link_loss_strap = 1'b1;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    void'($urandom(32'h0859bdeb));
    // terminal side, propagation bit from strap
    rst(1'b0, 1'b1);
    chk(phy_reset, 1'b0);
    rd(`LLC_ADDR_LB_CMD, `LLC_LB_CMD_RESET);
    rd(`LLC_ADDR_PHY_INIT, 8'h04);
    rd(8'h50, `LLC_RD_ZERO);
    link(1'b1, 1'b0, 2'b11);
    link(1'b0, 1'b1, 2'b11);
    link(1'b0, 1'b0, 2'b00);
    wr(`LLC_ADDR_PHY_INIT, 8'h02);
    link(1'b1, 1'b0, 2'b00);
    chk(fiber_tx_tristate, 1'b1);
    wr(`LLC_ADDR_PHY_INIT, 8'h00);
    link(1'b0, 1'b0, 2'b00);
    chk(fiber_tx_tristate, 1'b0);
    burst(8'h05, 0);
    burst(`LLC_LB_CMD_MAX, 0);
    n_phy = 0;
    wr(`LLC_ADDR_PHY_INIT, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(8'(n_phy), 8'h01);
    rd(`LLC_ADDR_PHY_INIT, 8'h00);
    rd(`LLC_ADDR_LB_CMD, `LLC_LB_CMD_MAX);
    zcmd(0);
    // center side: phy held until the 0x40 write
    rst(1'b1, 1'b1);
    chk(phy_reset, 1'b1);
    wr(`LLC_ADDR_PHY_INIT, 8'h04);
    link(1'b1, 1'b1, 2'b00);
    chk(phy_reset, 1'b1);
    wr(`LLC_ADDR_OAM_CFG, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(phy_reset, 1'b0);
    link(1'b0, 1'b0, 2'b00);
    burst(`LLC_LB_CMD_MIN, 1);
    burst(`LLC_LB_CMD_MAX, 100);
    n = 1 + $urandom % 100;
    burst(8'(n), n);
    burst(8'(n), n);
    burst(`LLC_LB_CMD_CLEAR, 0);
    // crc counting, read-only counter, clears
    @(posedge ref_clk);
    bad_crc <= 1'b1;
    burst(8'h04, 4);
    m_crc = 4;
    rd(`LLC_ADDR_LB_CRC, 8'(m_crc));
    wr(`LLC_ADDR_LB_CRC, 8'h55);
    rd(`LLC_ADDR_LB_CRC, 8'(m_crc));
    zcmd(1);
    m_crc = 0;
    rd(`LLC_ADDR_LB_CRC, 8'(m_crc));
    burst(8'h03, 3);
    m_crc = 3;
    rd(`LLC_ADDR_LB_CRC, 8'(m_crc));
    // soft reset pulse and self clear
    n_mac = 0;
    wr(`LLC_ADDR_PHY_INIT, 8'h14);
    repeat (4) @(posedge ref_clk);
    chk(8'(n_mac), 8'h01);
    rd(`LLC_ADDR_PHY_INIT, 8'h04);
    rd(`LLC_ADDR_LB_CMD, `LLC_LB_CMD_RESET);
    rd(`LLC_ADDR_LB_CRC, `LLC_CRC_CNT_RESET);
    summarize();
  end
endmodule
